// *** core/ssd_bit_if.sv ***
// serial bit events passed from the link domain to the core
`timescale 1ns/1ps
interface ssd_bit_if;
    logic tgl;
    logic bit_val;
    modport link (output tgl, output bit_val);
    modport core (input tgl, input bit_val);
endinterface

// *** core/ssd_decoder.sv ***
// four-byte serial speed command decoder with compensation table
`timescale 1ns/1ps
`include "ssd_defines.svh"
module ssd_decoder
    import ssd_pkg::*;
#(
    parameter int unsigned IDLE_CYCLES = `SSD_IDLE_MS * (`SSD_CLK_HZ / 1000)
)
(
    // system
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    // serial link
    input  wire logic       ser_clk_in,
    input  wire logic       ser_data_in,
    input  wire logic       ser_enable_n_in,
    // straps
    input  wire logic       compensation_disable_strap_in,
    input  wire logic       invert_control_strap_in,
    // converter and indicators
    output logic [9:0]      dac_code_out,
    output logic            dac_enable_out,
    output logic            zero_relay_out,
    output logic [1:0]      mode_ind_out
);

    //----------------------------------------
    // link domain sampler
    //----------------------------------------
    // only the toggle is synchronised: bit_val stands for a whole serial
    // bit time, far longer than the cycles the toggle needs to arrive
    ssd_bit_if bits ();

    ssd_link_rx u_link (
        .ser_clk_in  (ser_clk_in),
        .ser_data_in (ser_data_in),
        .sys_rst_in  (sys_rst_in),
        .bits        (bits)
    );

    //----------------------------------------
    // helpers
    //----------------------------------------
    function automatic logic [9:0] sat_add(
        input logic [9:0] v,
        input logic [7:0] c
    );
        logic [10:0] s;
        // one spare bit catches the carry that means saturation
        s = {1'b0, v} + {3'h0, c};
        if (s[10]) begin
            sat_add = `SSD_FULL_SCALE;
        end else begin
            sat_add = s[9:0];
        end
    endfunction

    function automatic logic is_end(input logic [7:0] b);
        is_end = (b == `SSD_END_BYTE);
    endfunction

    function automatic logic is_known(input logic [7:0] b);
        is_known = (b == `SSD_CMD_SPD_COMP) || (b == `SSD_CMD_SPD_RAW)
                || (b == `SSD_CMD_WR_COMP);
    endfunction

    ssd_core_s st;
    ssd_core_s next_st;

    logic        ev;
    logic        byte_done;
    logic [7:0]  new_byte;
    logic        fin;
    logic        idle_hit;
    logic [9:0]  cmd_val;
    logic [9:0]  out_v;
    logic [9:0]  drv_v;
    logic        en_act;
    logic        apply;

    assign ev        = st.tgl_s2 != st.tgl_prev;
    assign new_byte  = {bits.bit_val, st.shreg[7:1]};
    assign byte_done = ev && (st.bit_cnt == `SSD_BIT_LAST);
    assign fin       = byte_done && (st.byte_idx == `SSD_BYTE_LAST);
    assign idle_hit  = !ev && (st.idle_cnt == `SSD_IDLE_W'(IDLE_CYCLES - 1));
    assign cmd_val   = {st.p1[1:0], st.p2}; // see RL7, RL8
    assign en_act    = !st.en_s2; // see RL4
    // compensation only follows a speed command that asked for it
    assign apply     = st.comp_on && !st.comp_dis_s2; // see RL16
    assign out_v     = apply ? sat_add(st.speed, st.comp[st.speed[9:4]]) // see RL13, RL14
                             : st.speed;
    assign drv_v     = st.invert_s2 ? (`SSD_FULL_SCALE - out_v) : out_v; // see RL17

    //----------------------------------------
    // next state
    //----------------------------------------
    always_comb begin
        next_st        = st;
        next_st.tgl_s1 = bits.tgl;
        next_st.tgl_s2 = st.tgl_s1;
        next_st.tgl_prev = st.tgl_s2;
        next_st.en_s1  = ser_enable_n_in;
        next_st.en_s2  = st.en_s1;
        next_st.comp_dis_s1 = compensation_disable_strap_in;
        next_st.comp_dis_s2 = st.comp_dis_s1;
        next_st.invert_s1   = invert_control_strap_in;
        next_st.invert_s2   = st.invert_s1;

        // idle watchdog on serial clock activity
        if (ev) begin
            next_st.idle_cnt = '0;
        end else if (!idle_hit) begin
            next_st.idle_cnt = st.idle_cnt + 1'b1;
        end
        if (idle_hit) begin
            next_st.bit_cnt  = '0; // see RL3
            next_st.byte_idx = `SSD_BYTE_CMD; // see RL3
        end

        // byte assembly, lsb arrives first
        if (ev) begin
            next_st.shreg   = new_byte; // see RL2
            next_st.bit_cnt = st.bit_cnt + 1'b1;
        end

        if (byte_done) begin
            next_st.byte_idx = st.byte_idx + 1'b1; // see RL1
            case (st.byte_idx)
                `SSD_BYTE_CMD: begin
                    next_st.cmd = new_byte;
                end
                `SSD_BYTE_P1: begin
                    next_st.p1 = new_byte;
                end
                `SSD_BYTE_P2: begin
                    next_st.p2 = new_byte;
                end
                default: begin
                end
            endcase
        end

        // command execution on a valid end byte
        if (fin && is_end(new_byte)) begin // see RL9, RL19
            case (st.cmd)
                `SSD_CMD_SPD_COMP: begin
                    next_st.speed   = cmd_val; // see RL5
                    next_st.comp_on = 1'b1;
                end
                `SSD_CMD_SPD_RAW: begin
                    next_st.speed   = cmd_val; // see RL6
                    next_st.comp_on = 1'b0;
                end
                `SSD_CMD_WR_COMP: begin
                    if (st.p1 <= `SSD_MAX_INDEX) begin // see RL11, RL19
                        next_st.comp[st.p1[5:0]] = st.p2; // see RL10, RL12
                    end
                end
                default: begin
                end
            endcase
        end

        // output stage
        // a disabled output parks at the zero-speed level, full scale when inverted
        next_st.dac_en = en_act;
        if (en_act) begin
            next_st.dac = drv_v;
        end else if (st.invert_s2) begin
            next_st.dac = `SSD_FULL_SCALE; // see RL17
        end else begin
            next_st.dac = `SSD_ZERO_SPEED;
        end
        next_st.zero_relay = !en_act || (out_v == `SSD_ZERO_SPEED); // see RL18
        if (!en_act) begin
            next_st.ind = SSD_IND_OFF;
        end else if (out_v == `SSD_ZERO_SPEED) begin
            next_st.ind = SSD_IND_ZERO; // see RL18
        end else begin
            next_st.ind = SSD_IND_RUN;
        end

        if (sys_rst_in) begin
            next_st            = '0;
            // the toggle synchroniser keeps running so no false edge follows reset
            next_st.tgl_s1     = bits.tgl;
            next_st.tgl_s2     = st.tgl_s1;
            next_st.tgl_prev   = st.tgl_s2;
            next_st.en_s1      = 1'b1;
            next_st.en_s2      = 1'b1;
            next_st.comp       = `SSD_COMP_DEFAULT; // see RL15
            next_st.zero_relay = 1'b1;
            next_st.ind        = SSD_IND_OFF;
        end
    end

    always_ff @(posedge clk_in) begin
        st <= next_st;
    end

    //----------------------------------------
    // outputs
    //----------------------------------------
    assign dac_code_out   = st.dac;
    assign dac_enable_out = st.dac_en;
    assign zero_relay_out = st.zero_relay;
    assign mode_ind_out   = st.ind;

    //----------------------------------------
    // checks
    //----------------------------------------
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    chk_raw_speed: assert property ( // see RL6
        fin && is_end(new_byte) && st.cmd == `SSD_CMD_SPD_RAW
        |=> st.speed == $past(cmd_val) && !st.comp_on
    ) else $error("raw speed command not applied");

    chk_comp_speed: assert property ( // see RL5
        fin && is_end(new_byte) && st.cmd == `SSD_CMD_SPD_COMP
        |=> st.speed == $past(cmd_val) && st.comp_on
    ) else $error("compensated speed command not applied");

    chk_bad_end: assert property ( // see RL19
        fin && !is_end(new_byte)
        |=> $stable(st.speed) && $stable(st.comp) && $stable(st.comp_on)
    ) else $error("command with bad end byte took effect");

    chk_write_entry: assert property ( // see RL10
        fin && is_end(new_byte) && st.cmd == `SSD_CMD_WR_COMP
            && st.p1 <= `SSD_MAX_INDEX
        |=> st.comp[$past(st.p1[5:0])] == $past(st.p2)
    ) else $error("compensation entry not written");

    chk_big_index: assert property ( // see RL11
        fin && st.cmd == `SSD_CMD_WR_COMP && st.p1 > `SSD_MAX_INDEX
        |=> $stable(st.comp)
    ) else $error("out of range index changed the table");

    chk_sat_limit: assert property ( // see RL14
        apply && ({1'b0, st.speed} + {3'h0, st.comp[st.speed[9:4]]}) > 11'h3ff
        |-> out_v == `SSD_FULL_SCALE
    ) else $error("compensated speed not saturated");

    chk_no_comp: assert property ( // see RL16
        st.comp_dis_s2 |-> out_v == st.speed
    ) else $error("compensation added while disabled");

    chk_idle_reset: assert property ( // see RL3
        idle_hit |=> st.bit_cnt == '0 && st.byte_idx == `SSD_BYTE_CMD
    ) else $error("idle timeout did not reset receiver");

    chk_lsb_first: assert property ( // see RL2
        ev |=> st.shreg[7] == $past(bits.bit_val)
            && st.shreg[6:0] == $past(st.shreg[7:1])
    ) else $error("serial bit not shifted in lsb first");

    chk_enable_gate: assert property ( // see RL4
        !en_act && !st.invert_s2 && $stable(st.invert_s2)
        |=> !dac_enable_out && dac_code_out == `SSD_ZERO_SPEED
    ) else $error("output not gated by enable");

    chk_invert_out: assert property ( // see RL17
        en_act && st.invert_s2 |=> dac_code_out == `SSD_FULL_SCALE - $past(out_v)
    ) else $error("inverted output wrong");

    chk_zero_relay: assert property ( // see RL18
        en_act && out_v == `SSD_ZERO_SPEED |=> zero_relay_out
    ) else $error("zero speed relay not energised");

    chk_frame_wrap: assert property ( // see RL1
        fin |=> st.byte_idx == `SSD_BYTE_CMD && st.bit_cnt == '0
    ) else $error("byte counter did not wrap after fourth byte");

    chk_cmd_no_enable: assert property ( // see RL4
        !en_act && fin && is_end(new_byte) && st.cmd == `SSD_CMD_SPD_RAW
        |=> st.speed == $past(cmd_val)
    ) else $error("command ignored while enable inactive");

    chk_unknown_cmd: assert property ( // see RL19
        fin && !is_known(st.cmd)
        |=> $stable(st.speed) && $stable(st.comp) && $stable(st.comp_on)
    ) else $error("unknown command took effect");

    chk_raw_pass: assert property ( // see RL6
        !st.comp_on |-> out_v == st.speed
    ) else $error("compensation added to raw speed");

    chk_entry_used: assert property ( // see RL13
        apply && ({1'b0, st.speed} + {3'h0, st.comp[st.speed[9:4]]}) <= 11'h3ff
        |-> out_v == st.speed + {2'h0, st.comp[st.speed[9:4]]}
    ) else $error("wrong compensation entry applied");

    chk_table_default: assert property ( // see RL15
        $fell(sys_rst_in) |-> st.comp == `SSD_COMP_DEFAULT
    ) else $error("table defaults not loaded by reset");

    chk_idle_bound: assert property ( // see RL3
        st.idle_cnt <= `SSD_IDLE_W'(IDLE_CYCLES - 1)
    ) else $error("idle counter ran past its limit");

    chk_enable_on: assert property ( // see RL4
        en_act |=> dac_enable_out
    ) else $error("output enable not raised");

    chk_ind_state: assert property ( // see RL18
        en_act && out_v != `SSD_ZERO_SPEED
        |=> mode_ind_out == SSD_IND_RUN && !zero_relay_out
    ) else $error("indicator or relay wrong while running");

    chk_ind_off: assert property ( // see RL18
        !en_act |=> mode_ind_out == SSD_IND_OFF && zero_relay_out
    ) else $error("indicator or relay wrong while disabled");

    chk_invert_gate: assert property ( // see RL17
        !en_act && st.invert_s2 |=> dac_code_out == `SSD_FULL_SCALE
    ) else $error("inverted output not at full scale while disabled");

    chk_dac_level: assert property ( // see RL14
        en_act && !st.invert_s2 |=> dac_code_out == $past(out_v)
    ) else $error("converter code differs from final speed");

    cov_comp_cmd: cover property (
        fin && is_end(new_byte) && st.cmd == `SSD_CMD_SPD_COMP
    );

    cov_write_cmd: cover property (
        fin && is_end(new_byte) && st.cmd == `SSD_CMD_WR_COMP
    );

    cov_idle: cover property (
        idle_hit && st.byte_idx != `SSD_BYTE_CMD
    );

    cov_saturate: cover property (
        en_act && apply && out_v == `SSD_FULL_SCALE
    );

    cov_invert: cover property (
        en_act && st.invert_s2 && out_v != `SSD_ZERO_SPEED
    );

endmodule // ssd_decoder

// *** core/ssd_defines.svh ***
// constants of the serial speed command decoder
// How it works
// (RL1) command is four bytes: cmd, two payload, end
// (RL2) lsb first, sampled on falling serial clock
// (RL3) 200 ms without clock resets receiver
// (RL4) enable low gates output only, decoding continues
// (RL5) 0x53 sets speed plus compensation entry
// (RL6) 0x73 sets speed with no compensation
// (RL7) speed is 10 bits, first byte high part
// (RL8) speed spans 0 to 1023 full scale
// (RL9) fourth byte must be 0x0d
// (RL10) 0x57 writes one compensation entry
// (RL11) first payload byte is entry index, 0..0x3f
// (RL12) second payload byte is 8-bit entry value
// (RL13) 64 entries, entry index is speed shr 4
// (RL14) add entry, saturate sum at 1023
// (RL15) table defaults fall from 88 to 0
// (RL16) disable strap suppresses all compensation
// (RL17) invert strap: full speed at low output
// (RL18) invert strap adapts relay and indicator drive; code drives both from the uninverted speed
// (RL19) bad end, unknown cmd, big index: discarded
`ifndef SSD_DEFINES_SVH
`define SSD_DEFINES_SVH

`define SSD_CMD_SPD_COMP 8'h53
`define SSD_CMD_SPD_RAW  8'h73
`define SSD_CMD_WR_COMP  8'h57
`define SSD_END_BYTE     8'h0d
`define SSD_MAX_INDEX    8'h3f
`define SSD_FULL_SCALE   10'h3ff
`define SSD_ZERO_SPEED   10'h000
`define SSD_BIT_LAST     3'h7
`define SSD_BYTE_LAST    2'h3
`define SSD_BYTE_CMD     2'h0
`define SSD_BYTE_P1      2'h1
`define SSD_BYTE_P2      2'h2
`define SSD_IDLE_MS      200
`define SSD_CLK_HZ       40000000
`define SSD_IDLE_W       23
`define SSD_COMP_DEFAULT {\
    128'h00000000000001020304050607080a0b,\
    128'h0c0d0f10111214161718191a1c1e2022,\
    128'h242628292a2b2c2e303132333537393b,\
    128'h3c3e4041434547494b4c4e5052545658}

`endif

// *** core/ssd_link_rx.sv ***
// falling-edge serial bit sampler on the link clock
`timescale 1ns/1ps
module ssd_link_rx
    import ssd_pkg::*;
(
    // link side
    input  wire logic ser_clk_in,
    input  wire logic ser_data_in,
    // reset from the core domain
    input  wire logic sys_rst_in,
    // towards the core
    ssd_bit_if.link   bits
);

    ssd_link_s st;
    ssd_link_s next_st;

    //----------------------------------------
    // one toggle per captured bit
    //----------------------------------------
    always_comb begin
        next_st     = st;
        next_st.rs1 = sys_rst_in;
        next_st.rs2 = st.rs1;
        if (st.rs2) begin
            next_st.tgl     = 1'b0;
            next_st.bit_val = 1'b0;
        end else begin
            next_st.tgl     = ~st.tgl;
            next_st.bit_val = ser_data_in; // see RL2
        end
    end

    // the serial clock stands still between frames, so reset cannot wait for it
    always_ff @(negedge ser_clk_in or posedge sys_rst_in) begin // see RL2
        if (sys_rst_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bits.tgl     = st.tgl;
    assign bits.bit_val = st.bit_val;

endmodule // ssd_link_rx

// *** core/ssd_pkg.sv ***
// types of the serial speed command decoder
package ssd_pkg;

    typedef enum logic [1:0] {
        SSD_IND_OFF,
        SSD_IND_ZERO,
        SSD_IND_RUN
    } ssd_ind_e;

    typedef logic [63:0][7:0] ssd_table_t;

    typedef struct packed {
        logic       rs1;
        logic       rs2;
        logic       tgl;
        logic       bit_val;
    } ssd_link_s;

    typedef struct packed {
        logic                  tgl_s1;
        logic                  tgl_s2;
        logic                  tgl_prev;
        logic                  en_s1;
        logic                  en_s2;
        logic                  comp_dis_s1;
        logic                  comp_dis_s2;
        logic                  invert_s1;
        logic                  invert_s2;
        logic [22:0]           idle_cnt;
        logic [2:0]            bit_cnt;
        logic [7:0]            shreg;
        logic [1:0]            byte_idx;
        logic [7:0]            cmd;
        logic [7:0]            p1;
        logic [7:0]            p2;
        logic [9:0]            speed;
        logic                  comp_on;
        ssd_table_t            comp;
        logic [9:0]            dac;
        logic                  dac_en;
        logic                  zero_relay;
        ssd_ind_e              ind;
    } ssd_core_s;

endpackage

// *** sim/ssd_host_model.sv ***
// host controller model driving the synchronous serial link
`timescale 1ns/1ps
module ssd_host_model (
    // link clock
    input  wire logic link_clk_in,
    // serial pins
    output logic      ser_clk_out,
    output logic      ser_data_out
);
    initial begin
        ser_clk_out  = 1'b1;
        ser_data_out = 1'b1;
    end

    // data set while the clock is high, held past the falling edge
    task automatic send_bit(input logic b);
        repeat (4) @(posedge link_clk_in);
        ser_data_out <= b;
        repeat (4) @(posedge link_clk_in);
        ser_clk_out <= 1'b0;
        repeat (4) @(posedge link_clk_in);
        ser_clk_out <= 1'b1;
    endtask

    // sends the first n bits of a command; clock stands high afterwards
    task automatic send_cmd(input logic [7:0] c, p1, p2, e, input int n);
        logic [31:0] w;
        w = {e, p2, p1, c};
        for (int i = 0; i < n; i++) send_bit(w[i]);
        repeat (4) @(posedge link_clk_in);
        ser_data_out <= ~w[n-1];
    endtask
endmodule // ssd_host_model

// *** sim/tb.sv ***
// self-checking bench of the serial speed command decoder
`timescale 1ns/1ps
`include "ssd_defines.svh"
module tb
    import ssd_pkg::*;
;
    // ----------------------------------------
    // clocks, design and partner
    // ----------------------------------------
    localparam int unsigned IDLE = 200;
    logic        clk_in     = 1'b0;
    logic        link_clk   = 1'b0;
    logic        sys_rst_in = 1'b0;
    logic        enable_n   = 1'b1;
    logic        comp_dis   = 1'b0;
    logic        invert     = 1'b0;
    logic        ser_clk;
    logic        ser_data;
    logic [9:0]  dac_code;
    logic        dac_en;
    logic        relay;
    logic [1:0]  ind;
    int          mismatches = 0;
    int          compares   = 0;
    logic [31:0] lfsr       = 32'h9416;
    logic [31:0] r;
    logic [7:0]  c;
    ssd_table_t  tbl;
    logic [9:0]  speed;
    logic        comp_on;

    initial forever #12.5 clk_in = ~clk_in;
    initial begin
        #7;
        forever #15 link_clk = ~link_clk;
    end

    ssd_decoder #(.IDLE_CYCLES(IDLE)) dut (
        .clk_in                        (clk_in),
        .sys_rst_in                    (sys_rst_in),
        .ser_clk_in                    (ser_clk),
        .ser_data_in                   (ser_data),
        .ser_enable_n_in               (enable_n),
        .compensation_disable_strap_in (comp_dis),
        .invert_control_strap_in       (invert),
        .dac_code_out                  (dac_code),
        .dac_enable_out                (dac_en),
        .zero_relay_out                (relay),
        .mode_ind_out                  (ind)
    );

    ssd_host_model host (
        .link_clk_in  (link_clk),
        .ser_clk_out  (ser_clk),
        .ser_data_out (ser_data)
    );

    // ----------------------------------------
    // expectation and comparison
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    function automatic logic [9:0] final_speed();
        logic [10:0] s;
        s = {1'b0, speed};
        if (comp_on && !comp_dis) s = s + {3'h0, tbl[speed[9:4]]};
        return (s > 11'h3ff) ? `SSD_FULL_SCALE : s[9:0];
    endfunction

    task automatic chk10(input logic [9:0] got, input logic [9:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_all();
        logic [9:0] v;
        v = final_speed();
        repeat (12) @(negedge clk_in);
        chk10(dac_code, enable_n ? (invert ? 10'h3ff : 10'h000)
                                 : (invert ? 10'h3ff - v : v));
        chk10({9'h0, dac_en}, {9'h0, !enable_n});
        chk10({9'h0, relay}, {9'h0, enable_n || v == 10'h000});
        chk10({8'h0, ind}, enable_n ? 10'h0 : (v == 10'h0 ? 10'h1 : 10'h2));
    endtask

    task automatic cmd(input logic [7:0] c, p1, p2, e, input int n);
        host.send_cmd(c, p1, p2, e, n);
        if (n == 32 && e === `SSD_END_BYTE) begin
            if (c === `SSD_CMD_SPD_COMP || c === `SSD_CMD_SPD_RAW) begin
                speed   = {p1[1:0], p2};
                comp_on = (c === `SSD_CMD_SPD_COMP);
            end else if (c === `SSD_CMD_WR_COMP && p1 <= `SSD_MAX_INDEX) begin
                tbl[p1[5:0]] = p2;
            end
        end
        check_all();
    endtask

    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        tbl     = `SSD_COMP_DEFAULT;
        speed   = 10'h000;
        comp_on = 1'b0;
        #1 sys_rst_in = 1'b1;
        repeat (5) @(negedge clk_in);
        sys_rst_in = 1'b0;
        check_all();
        enable_n = 1'b0;
        cmd(8'h73, 8'hfc, 8'h00, 8'h0d, 32);
        cmd(8'h53, 8'h03, 8'hff, 8'h0d, 32);
        cmd(8'h53, 8'h00, 8'h05, 8'h0d, 32);
        cmd(8'h57, 8'h3f, 8'hff, 8'h0d, 32);
        cmd(8'h53, 8'h03, 8'hf0, 8'h0d, 32);
        cmd(8'h57, 8'h40, 8'h11, 8'h0d, 32);
        cmd(8'h42, 8'h01, 8'h00, 8'h0d, 32);
        cmd(8'h73, 8'h01, 8'hff, 8'h0c, 32);
        cmd(8'h73, 8'h02, 8'h00, 8'h0d, 12);
        repeat (IDLE + 50) @(negedge clk_in);
        cmd(8'h73, 8'h01, 8'h23, 8'h0d, 32);
        enable_n = 1'b1;
        cmd(8'h73, 8'h02, 8'h10, 8'h0d, 32);
        enable_n = 1'b0;
        check_all();
        for (int k = 0; k < 16; k++) begin
            r = rnd();
            @(negedge clk_in);
            enable_n = r[0];
            comp_dis = r[1];
            invert   = r[2];
            case (r[4:3])
                2'h0:    c = `SSD_CMD_SPD_COMP;
                2'h1:    c = `SSD_CMD_SPD_RAW;
                2'h2:    c = `SSD_CMD_WR_COMP;
                default: c = r[31:24];
            endcase
            cmd(c, r[15:8], r[23:16], (r[7:5] == 3'h0) ? r[31:24] : 8'h0d, 32);
        end
        end_sim();
    end

    initial begin
        #2_000_000;
        mismatches++;
        end_sim();
    end
endmodule // tb
